// ===== inc/dma_pkg.sv
package dma_pkg;

    // APB register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SRC = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_DST = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DPTR = 8'h14;

    // Channel control fields
    localparam int CTRL_W = 14;
    localparam int CTL_EN = 13;
    localparam int CTL_CHAIN = 12;
    localparam int CTL_PAUSE = 11;
    localparam int CTL_DBG = 10;
    localparam int CTL_DEMAND = 9;
    localparam int CTL_DUAL = 8;
    localparam int CTL_DS = 6;
    localparam int CTL_SS = 4;
    localparam int CTL_DHOLD = 3;
    localparam int CTL_SHOLD = 2;
    localparam int CTL_SIDE = 1;
    localparam int CTL_EXT = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;

    // Channel status fields
    localparam int STAT_W = 9;
    localparam int ST_DISDN = 8;
    localparam int ST_CERR = 7;
    localparam int ST_DERR = 6;
    localparam int ST_SERR = 5;
    localparam int ST_DR = 4;
    localparam int ST_CWB = 3;
    localparam int ST_CD = 2;
    localparam int ST_TC = 1;
    localparam int ST_EOPX = 0;
    localparam logic [STAT_W-1:0] STAT_RESET = 9'h000;

    // Transfer size encodings
    localparam logic [1:0] SZ_WORD = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_HALF = 2'h2;
    localparam logic [1:0] SZ_QUAD = 2'h3;
    localparam logic [4:0] QUAD_BYTES = 5'h10;
    localparam logic [4:0] WORD_BYTES = 5'h04;

    // Cycles from control write to first bus request
    localparam int START_DELAY_CYCLES = 2;

    // Bytes moved by one unit of a given size
    function automatic logic [4:0] unit_bytes(input logic [1:0] sz);
        unique case (sz)
            SZ_BYTE: unit_bytes = 5'h01;
            SZ_HALF: unit_bytes = 5'h02;
            SZ_WORD: unit_bytes = 5'h04;
            SZ_QUAD: unit_bytes = 5'h10;
        endcase
    endfunction : unit_bytes

endpackage : dma_pkg

// ===== rtl/sync_two_stage.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for pins from outside the pclk domain
module sync_two_stage #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : sync_two_stage

// ===== rtl/dma_channel.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module dma_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [dma_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral handshake
    input wire logic transfer_request_in_n,
    output logic transfer_ack_out_n,
    output logic rw_from_memory,
    input wire logic end_of_process_in_n,
    output logic end_of_process_out_n,
    output logic end_of_process_oe,
    // Bus interface unit
    output logic bus_req,
    output logic [29:0] bus_addr,
    output logic bus_write,
    output logic [1:0] bus_size,
    output logic bus_burst,
    output logic [31:0] bus_wdata,
    input wire logic bus_ready,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_fault
);
    import dma_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_ARM, S_WAIT, S_READ, S_WRITE, S_FLY, S_FETCH, S_PAUSE
    } state_t;

    state_t state, next_state;
    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [STAT_W-1:0] stat, next_stat, set_stat;
    logic [31:0] src, dst, count, dptr;
    logic [31:0] next_src, next_dst, next_count, next_dptr;
    logic [31:0] temp [4];
    logic [31:0] next_temp [4];
    logic [1:0] beat, next_beat;
    logic [4:0] pk, wk, next_pk, next_wk;
    logic [2:0] qerr, next_qerr, err_set;
    logic armed, next_armed, pending, next_pending;
    logic [1:0] pins_sync;
    logic req_n, eop_n, req_prev;
    logic clr_en, ent_done;
    logic [4:0] ent_bytes, ss_b, ds_b, step_s, step_d, grp;
    logic quad, chain, pausew, dbg, side, dual, edge_seen, ext_stop;
    logic setup, acc, apb_wr, final_ent, want_eop, beat_done;
    logic next_pready, next_pslverr;
    logic [31:0] next_prdata, mask, rd_word;
    logic [4:0] sh;
    logic next_bus_req, next_bus_write, next_bus_burst, next_ack_n;
    logic [29:0] next_bus_addr;
    logic [1:0] next_bus_size;
    logic [31:0] next_bus_wdata;
    logic next_rw, next_eop_oe, beat_next, periph;

    // Request and external stop pins, resynchronised
    sync_two_stage #(.WIDTH(2), .RESET_VAL(2'h3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({transfer_request_in_n, end_of_process_in_n}),
        .sync_out(pins_sync)
    );
    assign req_n = pins_sync[1];
    assign eop_n = pins_sync[0];

    // Decoded control
    assign chain = ctrl[CTL_CHAIN];
    assign pausew = ctrl[CTL_PAUSE];
    assign dbg = ctrl[CTL_DBG];
    assign dual = ctrl[CTL_DUAL];
    assign side = ctrl[CTL_SIDE];
    assign ss_b = unit_bytes(ctrl[CTL_SS +: 2]);
    assign ds_b = unit_bytes(ctrl[CTL_DS +: 2]);
    assign quad = (ctrl[CTL_SS +: 2] == SZ_QUAD);
    assign step_s = quad ? WORD_BYTES : ss_b;
    assign step_d = quad ? WORD_BYTES : ds_b;
    assign grp = quad ? QUAD_BYTES : (ss_b > ds_b ? ss_b : ds_b);
    assign ent_bytes = dual ? grp : ss_b;
    assign beat_done = bus_req & bus_ready;
    assign edge_seen = req_prev & ~req_n;
    assign ext_stop = ~eop_n & ~end_of_process_oe;
    assign final_ent = (count == {27'h0, ent_bytes});
    // Chain without options only signals at the very end of the chain
    assign want_eop = ~chain | pausew | dbg | (dptr == 32'h0);

    // APB phases; pready registered so the access phase always ends at once
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready;
    assign apb_wr = acc & pwrite;

    // Channel sequencing and datapath
    always_comb begin
        next_state = state;
        next_beat = beat;
        next_pk = pk;
        next_wk = wk;
        next_src = src;
        next_dst = dst;
        next_count = count;
        next_dptr = dptr;
        next_temp = temp;
        next_armed = armed;
        next_pending = pending;
        next_qerr = qerr;
        set_stat = '0;
        err_set = '0;
        clr_en = 1'b0;
        ent_done = 1'b0;
        sh = {pk[1:0], 3'h0};
        mask = (step_s == 5'h01) ? 32'h000000FF :
               (step_s == 5'h02) ? 32'h0000FFFF : 32'hFFFFFFFF;
        if (apb_wr && paddr == ADDR_SRC) next_src = pwdata;
        if (apb_wr && paddr == ADDR_DST) next_dst = pwdata;
        if (apb_wr && paddr == ADDR_COUNT) next_count = pwdata;
        if (apb_wr && paddr == ADDR_DPTR) next_dptr = pwdata;
        // Edges before the acknowledge are dropped, not queued
        if (armed && edge_seen) begin
            next_pending = 1'b1;
            next_armed = 1'b0;
        end
        if (!transfer_ack_out_n) next_armed = 1'b1;
        unique case (state)
            S_IDLE: begin
                if (ctrl[CTL_EN]) begin
                    next_state = S_ARM;
                    next_armed = 1'b1;
                    next_pending = 1'b0;
                end
            end
            S_ARM, S_WAIT, S_PAUSE: begin
                if (!ctrl[CTL_EN]) begin
                    next_state = S_IDLE;
                    set_stat[ST_DISDN] = 1'b1;
                end else if (state == S_PAUSE) begin
                    if (!stat[ST_CWB]) next_state = S_WAIT;
                end else if (ext_stop) begin
                    next_state = S_IDLE;
                    set_stat[ST_EOPX] = 1'b1;
                    clr_en = 1'b1;
                end else if (!ctrl[CTL_EXT] ||
                             (ctrl[CTL_DEMAND] ? !req_n : pending)) begin
                    // Start here lands the first request on the next edge
                    next_state = dual ? S_READ : S_FLY;
                    next_beat = 2'h0;
                    next_pk = 5'h0;
                    next_wk = 5'h0;
                    next_qerr = 3'h0;
                    if (!ctrl[CTL_DEMAND]) next_pending = 1'b0;
                end
            end
            S_FLY: begin
                if (beat_done) begin
                    next_beat = beat + 2'h1;
                    if (!ctrl[CTL_SHOLD] && side) next_src = src + 32'h1;
                    if (!ctrl[CTL_DHOLD] && !side) next_dst = dst + 32'h1;
                    if (bus_fault) next_qerr = side ? 3'h1 : 3'h2;
                    if (bus_fault && !quad) err_set = side ? 3'h1 : 3'h2;
                    else if (!quad || beat == 2'h3) begin
                        if (next_qerr != 3'h0 || qerr != 3'h0)
                            err_set = qerr | next_qerr;
                        else ent_done = 1'b1;
                    end
                end
            end
            S_READ: begin
                if (beat_done) begin
                    next_temp[pk[3:2]] = ((bus_rdata & mask) << sh) |
                        (temp[pk[3:2]] & ~(mask << sh));
                    next_pk = pk + step_s;
                    if (!ctrl[CTL_SHOLD]) next_src = src + 32'h1;
                    if (bus_fault) next_qerr = 3'h1;
                    if (bus_fault && !quad) err_set = 3'h1;
                    else if (next_pk >= grp) begin
                        // A quad read fault still completes the burst first
                        if (next_qerr != 3'h0) err_set = next_qerr;
                        else next_state = S_WRITE;
                    end
                end
            end
            S_WRITE: begin
                if (beat_done) begin
                    next_wk = wk + step_d;
                    if (!ctrl[CTL_DHOLD]) next_dst = dst + 32'h1;
                    if (bus_fault) next_qerr = 3'h2;
                    if (bus_fault && !quad) err_set = 3'h2;
                    else if (next_wk >= grp) begin
                        if (next_qerr != 3'h0) err_set = next_qerr;
                        else ent_done = 1'b1;
                    end
                end
            end
            S_FETCH: begin
                if (beat_done) begin
                    next_beat = beat + 2'h1;
                    unique case (beat)
                        2'h0: next_src = bus_rdata;
                        2'h1: next_dst = bus_rdata;
                        2'h2: next_count = bus_rdata;
                        2'h3: next_dptr = bus_rdata;
                    endcase
                    if (bus_fault) err_set = 3'h4;
                    else if (beat == 2'h3) next_state = S_WAIT;
                end
            end
        endcase
        // Buffer bookkeeping at the end of each entity
        if (ent_done) begin
            next_count = count - {27'h0, ent_bytes};
            if (next_count == 32'h0) begin
                if (!chain || dbg) set_stat[ST_TC] = 1'b1;
                if (chain && pausew) begin
                    set_stat[ST_CWB] = 1'b1;
                    next_state = S_PAUSE;
                end else if (chain && dptr != 32'h0) begin
                    next_state = S_FETCH;
                    next_beat = 2'h0;
                end else begin
                    if (chain) set_stat[ST_CD] = 1'b1;
                    next_state = S_IDLE;
                    clr_en = 1'b1;
                end
            end else begin
                next_state = S_WAIT;
            end
        end
        // Faults stop the channel at once, quad burst faults only at the end of the burst
        if (err_set != 3'h0) begin
            set_stat[ST_SERR] = err_set[0];
            set_stat[ST_DERR] = err_set[1];
            set_stat[ST_CERR] = err_set[2];
            next_state = S_IDLE;
            clr_en = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            beat <= 2'h0;
            pk <= 5'h0;
            wk <= 5'h0;
            src <= 32'h0;
            dst <= 32'h0;
            count <= 32'h0;
            dptr <= 32'h0;
            temp <= '{default: 32'h0};
            armed <= 1'b0;
            pending <= 1'b0;
            qerr <= 3'h0;
            req_prev <= 1'b1;
        end else begin
            state <= next_state;
            beat <= next_beat;
            pk <= next_pk;
            wk <= next_wk;
            src <= next_src;
            dst <= next_dst;
            count <= next_count;
            dptr <= next_dptr;
            temp <= next_temp;
            armed <= next_armed;
            pending <= next_pending;
            qerr <= next_qerr;
            req_prev <= req_n;
        end
    end

    // Pin and bus drive, all taken from next-state values
    always_comb begin
        beat_next = (next_state == S_READ) || (next_state == S_WRITE) ||
                    (next_state == S_FLY) || (next_state == S_FETCH);
        periph = (next_state == S_FLY) ||
                 (next_state == S_READ && !side) ||
                 (next_state == S_WRITE && side);
        // One idle cycle after every ready drops both request and ack
        next_bus_req = beat_next && !beat_done;
        next_ack_n = !(periph && !beat_done);
        next_rw = (next_state == S_FLY) && side;
        next_bus_burst = quad && beat_next && (next_state != S_FETCH);
        next_bus_write = 1'b0;
        next_bus_size = ctrl[CTL_SS +: 2];
        next_bus_addr = next_src[29:0];
        unique case (next_state)
            S_FLY: begin
                next_bus_write = !side;
                next_bus_addr = side ? next_src[29:0] : next_dst[29:0];
            end
            S_WRITE: begin
                next_bus_write = 1'b1;
                next_bus_size = ctrl[CTL_DS +: 2];
                next_bus_addr = next_dst[29:0];
            end
            S_FETCH: begin
                next_bus_size = SZ_WORD;
                next_bus_addr = next_dptr[29:0] + {28'h0, next_beat};
            end
            default: begin
            end
        endcase
        next_bus_wdata = next_temp[next_wk[3:2]] >> {next_wk[1:0], 3'h0};
        // Error bits hold the line until software clears them
        next_eop_oe = (next_stat[ST_SERR] | next_stat[ST_DERR] |
                       next_stat[ST_CERR]) |
                      (beat_next && !beat_done && periph &&
                       final_ent && want_eop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_req <= 1'b0;
            bus_addr <= 30'h0;
            bus_write <= 1'b0;
            bus_size <= SZ_WORD;
            bus_burst <= 1'b0;
            bus_wdata <= 32'h0;
            transfer_ack_out_n <= 1'b1;
            rw_from_memory <= 1'b0;
            end_of_process_oe <= 1'b0;
            end_of_process_out_n <= 1'b1;
        end else begin
            bus_req <= next_bus_req;
            bus_addr <= next_bus_addr;
            bus_write <= next_bus_write;
            bus_size <= next_bus_size;
            bus_burst <= next_bus_burst;
            bus_wdata <= next_bus_wdata;
            transfer_ack_out_n <= next_ack_n;
            rw_from_memory <= next_rw;
            end_of_process_oe <= next_eop_oe;
            end_of_process_out_n <= !next_eop_oe;
        end
    end

    // Register file: control, write-one-to-clear status, read mux
    always_comb begin
        next_pready = setup;
        next_pslverr = setup && !(paddr == ADDR_CTRL || paddr == ADDR_STAT ||
                       paddr == ADDR_SRC || paddr == ADDR_DST ||
                       paddr == ADDR_COUNT || paddr == ADDR_DPTR);
        next_ctrl = ctrl;
        if (apb_wr && paddr == ADDR_CTRL) next_ctrl = pwdata[CTRL_W-1:0];
        else if (clr_en) next_ctrl[CTL_EN] = 1'b0;
        next_stat = stat;
        if (apb_wr && paddr == ADDR_STAT)
            next_stat = stat & ~pwdata[STAT_W-1:0];
        next_stat = next_stat | set_stat; // set beats a same-cycle clear
        unique case (paddr)
            ADDR_CTRL: rd_word = {18'h0, ctrl};
            ADDR_STAT: rd_word = {23'h0, stat[8:5],
                                  pending | (ctrl[CTL_DEMAND] & !req_n),
                                  stat[3:0]};
            ADDR_SRC: rd_word = src;
            ADDR_DST: rd_word = dst;
            ADDR_COUNT: rd_word = count;
            ADDR_DPTR: rd_word = dptr;
            default: rd_word = 32'h0;
        endcase
        next_prdata = (setup && !pwrite) ? rd_word : prdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            stat <= STAT_RESET;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            stat <= next_stat;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule : dma_channel

// ===== verif/dma_sva.sv
`timescale 1ns/1ps
// Pin checks on the channel, bound into every instance
module dma_sva (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [dma_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Peripheral and bus unit
    input wire logic transfer_ack_out_n,
    input wire logic end_of_process_out_n,
    input wire logic end_of_process_oe,
    input wire logic bus_req,
    input wire logic [29:0] bus_addr,
    input wire logic bus_ready,
    input wire logic bus_burst,
    input wire logic bus_fault
);
    import dma_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed APB write that starts a software block transfer
    sequence sw_start;
        psel && penable && pready && pwrite && paddr == ADDR_CTRL
            && pwdata[CTL_EN] && !pwdata[CTL_EXT];
    endsequence
    sequence beat_end;
        bus_req && bus_ready;
    endsequence
    a_start_delay: assert property (
        sw_start |=> !bus_req ##[1:2] bus_req) else $error("late start");
    a_bus_release: assert property (
        beat_end |=> !bus_req) else $error("bus not released");
    a_req_held: assert property (
        bus_req && !bus_ready |=> bus_req && $stable(bus_addr))
        else $error("request moved");
    a_ack_in_beat: assert property (
        !transfer_ack_out_n |-> bus_req) else $error("stray ack");
    a_ack_with_req: assert property (
        $fell(transfer_ack_out_n) |-> $rose(bus_req)) else $error("ack early");
    a_ack_drops: assert property (
        beat_end ##0 !transfer_ack_out_n |=> transfer_ack_out_n)
        else $error("ack held");
    a_eop_drive: assert property (
        end_of_process_out_n == !end_of_process_oe) else $error("eop pin");
    a_fault_eop: assert property (
        beat_end ##0 bus_fault && !bus_burst |-> ##[1:2] end_of_process_oe)
        else $error("no eop on fault");
endmodule : dma_sva

bind dma_channel dma_sva u_sva (.*);

// ===== verif/periph_model.sv
`timescale 1ns/1ps
// Peripheral on the request and acknowledge pins
module periph_model (
    // Clock, reset and bench commands
    input wire logic pclk,
    input wire logic presetn,
    input wire logic kick,
    input wire logic level,
    input wire logic slow,
    input wire logic stop,
    // Pins
    input wire logic transfer_ack_out_n,
    output logic transfer_request_in_n,
    output logic end_of_process_in_n
);
    logic [3:0] hold, next_hold;
    // Prompt pulses end on acknowledge; slow ones outlast the transfer
    always_comb begin
        next_hold = hold - {3'h0, hold != 4'h0};
        if (!transfer_ack_out_n && !slow) begin
            next_hold = 4'h0;
        end
        if (kick) begin
            next_hold = 4'hF;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 4'h0;
        end else begin
            hold <= next_hold;
        end
    end
    // Each pulse is one high-to-low step; demand holds the level
    assign transfer_request_in_n = !(level ||
                                     hold != 4'h0);
    // External stop only on bench command; else rests at pull-up level
    assign end_of_process_in_n = !stop;
endmodule : periph_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
// Self-checking bench: APB programming, bus unit stub, peripheral
module testbench;
    import dma_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, bus_ready = 1'b0, bus_fault = 1'b0;
    logic fault_arm = 1'b0, kick = 1'b0, level = 1'b0, slow = 1'b0;
    logic eop_seen = 1'b0, ack_prev = 1'b1;
    logic last_rw = 1'b0, last_burst = 1'b0, stop = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, bus_rdata = '0;
    logic [31:0] prdata, bus_wdata, q, last_wdata;
    logic [29:0] bus_addr, last_addr;
    logic [1:0] bus_size;
    logic pready, pslverr, e, transfer_request_in_n, transfer_ack_out_n;
    logic rw_from_memory, end_of_process_in_n, end_of_process_out_n;
    logic end_of_process_oe, bus_req, bus_write, bus_burst;
    int err_total = 0, checked = 0, beats = 0, acks = 0;
    dma_channel dut (.*);
    periph_model peer (.*);
    always #4 pclk = ~pclk;
    // Bus unit: ready one cycle after request, read data from address
    always @(posedge pclk) begin
        bus_ready <= bus_req && !bus_ready;
        bus_fault <= fault_arm && bus_req && !bus_ready;
        bus_rdata <= {24'h0, bus_addr[7:0]};
        ack_prev <= transfer_ack_out_n;
        if (!transfer_ack_out_n && ack_prev) acks <= acks + 1;
        if (end_of_process_oe) eop_seen <= 1'b1;
        if (bus_req && bus_ready) begin
            beats <= beats + 1;
            last_addr <= bus_addr;
            last_rw <= rw_from_memory;
            last_burst <= bus_burst;
            fault_arm <= 1'b0;
            if (bus_write) last_wdata <= bus_wdata;
        end
    end
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] x, y);
        checked++;
        if (y !== x) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, x, y);
        end
    endtask : chk
    // Poll status until a bit sets; the bound keeps a hang short
    task automatic wait_bit(input int b);
        q = '0;
        for (int i = 0; i < 200 && q[b] !== 1'b1; i++) begin
            apb(1'b0, ADDR_STAT, '0);
        end
        // A bound that runs out is a mismatch, not a silent pass
        if (q[b] !== 1'b1) begin
            err_total++;
            $display("unexpected status %0d: expected 1, seen %b", b, q[b]);
        end
    endtask : wait_bit
    task automatic run(input logic [13:0] c, input logic [31:0] s, n);
        apb(1'b1, ADDR_STAT, 32'h1FF);
        apb(1'b1, ADDR_SRC, s);
        apb(1'b1, ADDR_COUNT, n);
        beats = 0;
        acks = 0;
        eop_seen = 1'b0;
        apb(1'b1, ADDR_CTRL, {18'h0, c});
    endtask : run
    task automatic results;
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, '0);
        chk("ctrl reset", {18'h0, CTRL_RESET}, q);
        apb(1'b0, 8'h18, '0);
        chk("unmapped error", 32'h1, {31'h0, e});
        // Block flyby to the device, two words
        run(14'h2002, 32'h100, 32'h8);
        wait_bit(ST_TC);
        chk("beats, acks", 32'h00020002, {16'(beats), 16'(acks)});
        chk("eop rw addr", 32'hC0000101,
            {eop_seen, last_rw, last_addr});
        // Quad flyby: four single-address word beats, burst flagged
        run(14'h20F2, 32'h100, 32'h10);
        wait_bit(ST_TC);
        chk("quad beats, acks", 32'h00040004,
            {16'(beats), 16'(acks)});
        chk("quad eop burst addr", 32'hC0000103,
            {eop_seen, last_burst, last_addr});
        // Flowthru bytes packed into one word
        run(14'h2110, 32'h40, 32'h4);
        wait_bit(ST_TC);
        chk("beats, acks", 32'h00050004, {16'(beats), 16'(acks)});
        chk("packed word", 32'h43424140, last_wdata);
        // Single mode: a long pulse still moves one entity
        run(14'h2001, 32'h100, 32'h8);
        slow <= 1'b1;
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("one pulse", 32'h1, 32'(beats));
        slow <= 1'b0;
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        wait_bit(ST_TC);
        chk("single count", 32'h2, 32'(beats));
        chk("rw low", 32'h0, {31'h0, last_rw});
        run(14'h2201, 32'h100, 32'hC);
        level <= 1'b1;
        wait_bit(ST_TC);
        level <= 1'b0;
        chk("demand beats", 32'h3, 32'(beats));
        // External stop ends a waiting single-mode channel
        run(14'h2001, 32'h100, 32'h8);
        stop <= 1'b1;
        wait_bit(ST_EOPX);
        stop <= 1'b0;
        chk("stopped beats", 32'h0, 32'(beats));
        // Chain pause: one buffer, halt, resume after the status clear
        run(14'h3802, 32'h100, 32'h4);
        wait_bit(ST_CWB);
        chk("pause beats, eop", 32'h00010001,
            {16'(beats), 15'h0, eop_seen});
        apb(1'b1, ADDR_COUNT, 32'h4);
        apb(1'b1, ADDR_STAT, 32'h8);
        wait_bit(ST_CWB);
        chk("resumed beats", 32'h2, 32'(beats));
        apb(1'b1, ADDR_CTRL, '0);
        // Faulted beat holds end-of-process until the bit is cleared
        fault_arm <= 1'b1;
        run(14'h2002, 32'h100, 32'h8);
        wait_bit(ST_SERR);
        chk("fault eop", 32'h1, {31'h0, end_of_process_oe});
        apb(1'b1, ADDR_STAT, 32'h20);
        repeat (3) @(posedge pclk);
        chk("eop cleared", 32'h0, {31'h0, end_of_process_oe});
        results;
    end
    // Watchdog sized well past the longest run
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results;
    end
endmodule : testbench
